// [bench/pcd_ctrl_model.sv]
// motion controller model driving the two command inputs
`timescale 1ns/1ns
`default_nettype none
module pcd_ctrl_model (
   input  wire logic clk,     // system clock
   output var  logic first,   // step, up, pwm or phase a
   output var  logic second   // direction, down or phase b
);
   initial begin
      first <= 1'b0;
      second <= 1'b0;
   end

   // =====================================================================
   // levels change just after an edge and stay put for n cycles
   task automatic hold(input logic a, input logic b, input int n);
      first <= a;
      second <= b;
      repeat (n) @(posedge clk);
   endtask

   // whole periods only, so the measured duty stays exact
   task automatic pwm(input int hi, input int lo, input logic dir, input int n);
      repeat (n / (hi + lo)) begin
         hold(1'b1, dir, hi);
         hold(1'b0, dir, lo);
      end
   endtask
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// self-checking bench for the pulse command decoder
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
   $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g); end end
module tb_top;
   import pcd_pkg::*;
   logic               clk, reset, first, second;
   pcd_mode_t          mode;
   pcd_ratio_t         ratio;
   pcd_out_t           status;
   logic signed [31:0] expPos;
   logic signed [11:0] lastCmd;
   int                 err_count, n_tests, nValid, nQuadErr;

   pcd_ctrl_model ctl_u (.clk(clk), .first(first), .second(second));
   pcd_decoder dut_u (.clk(clk), .reset(reset), .commandInputFirst(first),
      .commandInputSecond(second), .mode(mode), .ratio(ratio), .status(status));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk) begin
      if (status.commandValid === 1'b1) begin
         lastCmd <= status.command;
         nValid <= nValid + 1;
      end
      if (status.quadError === 1'b1) nQuadErr <= nQuadErr + 1;
   end

   // =====================================================================
   // helpers
   task automatic give_verdict();
      if (err_count == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // idle level first, so direction is settled before every pulse
   task automatic pulses(input logic a, b, ia, ib, input int n);
      repeat (n) begin
         ctl_u.hold(ia, ib, 2);
         ctl_u.hold(a, b, 2);
      end
      ctl_u.hold(ia, ib, 8);
   endtask

   task automatic quad_seq(input logic [3:0] sa, input logic [3:0] sb);
      for (int i = 3; i >= 0; i--) ctl_u.hold(sa[i], sb[i], 3);
      ctl_u.hold(sa[0], sb[0], 6);
   endtask

   // =====================================================================
   // scenarios
   task automatic test_step();
      pulses(1'b1, 1'b1, 1'b0, 1'b1, 3);
      expPos += 3;
      `CHK("step fwd", expPos, status.position)
      pulses(1'b1, 1'b0, 1'b0, 1'b0, 2);
      expPos -= 2;
      `CHK("step rev", expPos, status.position)
   endtask

   task automatic test_ratio();
      ratio <= '{16'h0001, 16'h0002};
      pulses(1'b1, 1'b1, 1'b0, 1'b1, 4);
      expPos += 2;
      `CHK("ratio half", expPos, status.position)
      ratio <= '{16'h0003, 16'h0001};
      pulses(1'b1, 1'b1, 1'b0, 1'b1, 1);
      expPos += 3;
      `CHK("ratio triple", expPos, status.position)
      ratio <= '{16'h0001, 16'h0001};
   endtask

   task automatic test_updn();
      ctl_u.hold(1'b0, 1'b0, 4);
      mode <= PCD_MODE_UPDN;
      pulses(1'b1, 1'b0, 1'b0, 1'b0, 3);
      pulses(1'b0, 1'b1, 1'b0, 1'b0, 1);
      expPos += 2;
      `CHK("up down", expPos, status.position)
   endtask

   task automatic test_quad();
      int n0;
      mode <= PCD_MODE_QUAD;
      quad_seq(4'hC, 4'h6);
      expPos += 4;
      `CHK("quad fwd", expPos, status.position)
      quad_seq(4'h6, 4'hC);
      expPos -= 4;
      `CHK("quad rev", expPos, status.position)
      n0 = nQuadErr;
      ctl_u.hold(1'b1, 1'b1, 4);
      ctl_u.hold(1'b0, 1'b0, 8);
      `CHK("quad both", expPos, status.position)
      `CHK("quad error", n0 + 2, nQuadErr)
   endtask

   // mid-run reset clears the position; sync stages restart without a false edge
   task automatic test_reset();
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      mode <= PCD_MODE_STEP;
      expPos = 32'sh0000_0000;
      @(posedge clk);
      `CHK("reset mid", expPos, status.position)
      pulses(1'b1, 1'b1, 1'b0, 1'b1, 2);
      expPos += 2;
      `CHK("after reset", expPos, status.position)
   endtask

   // the last completed window lies wholly inside the pattern, so it decides
   task automatic pwm_case(input pcd_mode_t m, input int hi, input int lo,
                           input logic dir, input logic signed [11:0] e);
      int n0;
      n0 = nValid;
      mode <= m;
      if (lo == 0) ctl_u.hold(1'b1, dir, 2400);
      else if (hi == 0) ctl_u.hold(1'b0, dir, 2400);
      else ctl_u.pwm(hi, lo, dir, 2400);
      `CHK("pwm valid", 1'b1, (nValid > n0))
      `CHK("pwm command", e, lastCmd)
   endtask

   // =====================================================================
   // main sequence and watchdog
   initial begin
      reset <= 1'b1;
      mode <= PCD_MODE_STEP;
      ratio <= '{16'h0001, 16'h0001};
      expPos = 32'sh0000_0000;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      `CHK("reset pos", expPos, status.position)
      test_step();
      test_ratio();
      test_updn();
      test_quad();
      test_reset();
      pwm_case(PCD_MODE_PWMDIR, 1, 3, 1'b0, -12'sh100);
      pwm_case(PCD_MODE_PWMDIR, 1, 3, 1'b1, 12'sh100);
      pwm_case(PCD_MODE_PWM50, 1, 1, 1'b0, 12'sh000);
      pwm_case(PCD_MODE_PWM50, 1, 0, 1'b0, 12'sh400);
      pwm_case(PCD_MODE_PWM50, 0, 1, 1'b0, -12'sh400);
      give_verdict();
   end

   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      give_verdict();
   end
endmodule
`default_nettype wire

// [hdl/pcd_decoder.sv]
// pulse command decoder: position and velocity/torque command from two inputs
// Function
// R01 - In step mode each step pulse advances the commanded position by one increment.
// R02 - In step mode the direction input level picks the sign of each increment.
// R03 - In up/down mode pulses on the first input move CW and on the second CCW.
// R04 - Quadrature mode lets the position follow another motor's encoder (gearing).
// R05 - All pulse position formats scale input pulses by a programmable ratio.
// R06 - Quadrature mode takes direction and rate from input phase and edge rate.
// R07 - In PWM/direction mode the command magnitude is the measured duty cycle.
// R08 - In PWM/direction mode the direction level sets the command sign.
// R09 - Single-signal PWM uses one input and half duty gives a zero command.
// R10 - Single-signal PWM maps full duty to +full scale and zero duty to -full scale.
// R11 - Both inputs pass two synchronising flip-flops before edge or duty logic.
// R12 - Quadrature counts every edge of both inputs and ignores simultaneous changes.
`timescale 1ns/1ns
`default_nettype none
module pcd_decoder (
   input  wire logic      clk,                 // system clock, 10 MHz
   input  wire logic      reset,               // synchronous, active high
   input  wire logic      commandInputFirst,   // step, up, pwm or phase a
   input  wire logic      commandInputSecond,  // direction, down or phase b
   input  wire pcd_pkg::pcd_mode_t  mode,      // command format
   input  wire pcd_pkg::pcd_ratio_t ratio,     // counts per input pulse ratio
   output pcd_pkg::pcd_out_t        status     // registered results
);
   import pcd_pkg::*;

   // =====================================================================
   // signed increment of num, sign true moves clockwise (positive)
   function automatic logic signed [ACC_W-1:0] pcd_scale(input logic sign,
                                                          input logic [15:0] num);
      logic signed [ACC_W-1:0] mag;
      mag = $signed({9'h000, num});
      pcd_scale = sign ? mag : -mag;
   endfunction

   logic [1:0] level;
   logic [1:0] prev;
   logic [1:0] rise;
   logic [1:0] chg;

   pcd_sync u_sync (
      .clk   (clk),
      .reset (reset),
      .din   ({commandInputSecond, commandInputFirst}),
      .level (level),
      .prev  (prev)
   );

   assign rise = level & ~prev;  // [R11]
   assign chg  = level ^ prev;   // [R11]

   pcd_state_t              st;
   pcd_state_t              next_st;
   logic signed [ACC_W-1:0] delta;
   logic signed [ACC_W-1:0] sum;
   logic signed [ACC_W-1:0] denS;
   logic                    quadIllegal;
   logic [10:0]             highNext;
   logic [11:0]             twiceHigh;
   logic                    pwmMode;

   // =====================================================================
   // pulse decoding and ratio scaling
   always_comb begin
      next_st              = st;
      next_st.commandValid = 1'b0;
      delta                = '0;
      quadIllegal          = 1'b0;
      case (mode)
         PCD_MODE_STEP: begin
            if (rise[0]) begin
               delta = pcd_scale(level[1], ratio.num);  // [R01] [R02]
            end
         end
         PCD_MODE_UPDN: begin
            // coincident up and down pulses cancel out
            if (rise[0] && !rise[1]) begin
               delta = pcd_scale(1'b1, ratio.num);      // [R03]
            end else if (rise[1] && !rise[0]) begin
               delta = pcd_scale(1'b0, ratio.num);      // [R03]
            end
         end
         PCD_MODE_QUAD: begin
            if (chg == 2'h3) begin
               quadIllegal = 1'b1;                      // [R12]
            end else if (chg[0]) begin
               delta = pcd_scale(level[0] != level[1], ratio.num);  // [R04] [R06] [R12]
            end else if (chg[1]) begin
               delta = pcd_scale(level[0] == level[1], ratio.num);  // [R06] [R12]
            end
         end
         default: begin
            delta = '0;
         end
      endcase
      next_st.quadError = quadIllegal;

      // a zero denominator is treated as one to keep the drain bounded
      denS = (ratio.den == 16'h0000) ? 25'sh000_0001 : $signed({9'h000, ratio.den});
      sum  = st.acc + delta;
      // at most one motor count per clock; num well above den lags fast pulses
      if (sum >= denS) begin
         next_st.position = st.position + 32'sh0000_0001;  // [R05]
         next_st.acc      = sum - denS;
      end else if (sum <= -denS) begin
         next_st.position = st.position - 32'sh0000_0001;  // [R05]
         next_st.acc      = sum + denS;
      end else begin
         next_st.acc      = sum;
      end

      // duty is measured over a fixed window, so no divider is needed
      pwmMode   = (mode == PCD_MODE_PWMDIR) || (mode == PCD_MODE_PWM50);
      highNext  = st.highCnt + {10'h000, level[0]};
      twiceHigh = {highNext, 1'b0};
      if (st.windowCnt == PWM_WIN_LAST) begin
         next_st.windowCnt = CNT_RESET;
         next_st.highCnt   = CNT_RESET;
         if (mode == PCD_MODE_PWMDIR) begin
            next_st.command      = level[1] ? $signed({1'b0, highNext})
                                            : -$signed({1'b0, highNext});  // [R07] [R08]
            next_st.commandValid = 1'b1;
         end else if (mode == PCD_MODE_PWM50) begin
            next_st.command      = $signed(twiceHigh - PWM_FULL);  // [R09] [R10]
            next_st.commandValid = 1'b1;
         end
      end else begin
         next_st.windowCnt = st.windowCnt + 11'h001;
         next_st.highCnt   = highNext;
      end
      if (!pwmMode) begin
         next_st.command = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st.position     <= POS_RESET;
         st.acc          <= ACC_RESET;
         st.windowCnt    <= CNT_RESET;
         st.highCnt      <= CNT_RESET;
         st.command      <= CMD_RESET;
         st.commandValid <= 1'b0;
         st.quadError    <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // one driver for the whole output struct
   assign status = '{position:     st.position,
                     command:      st.command,
                     commandValid: st.commandValid,
                     quadError:    st.quadError};

   // =====================================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_sync_two_stage: assert property (  // [R11]
      ##3 level == $past({commandInputSecond, commandInputFirst}, 2))
      else $error("synchronised level is not input delayed two cycles");

   a_step_increment: assert property (  // [R01]
      mode == PCD_MODE_STEP && rise[0] && level[1] |-> delta == $signed({9'h000, ratio.num}))
      else $error("step pulse did not add a positive increment");

   a_step_direction: assert property (  // [R02]
      mode == PCD_MODE_STEP && rise[0] && !level[1] |-> delta == -$signed({9'h000, ratio.num}))
      else $error("step with direction low did not subtract");

   a_updn_sense: assert property (  // [R03]
      mode == PCD_MODE_UPDN && rise[1] && !rise[0] && ratio.num != 16'h0000 |-> delta < 0)
      else $error("down pulse did not move counter-clockwise");

   a_updn_up: assert property (  // [R03]
      mode == PCD_MODE_UPDN && rise[0] && !rise[1] && ratio.num != 16'h0000 |-> delta > 0)
      else $error("up pulse did not move clockwise");

   a_quad_forward: assert property (  // [R06]
      mode == PCD_MODE_QUAD && prev == 2'h0 && level == 2'h1 && ratio.num != 16'h0000
      |-> delta > 0)
      else $error("phase a leading did not count up");

   a_quad_reverse: assert property (  // [R04]
      mode == PCD_MODE_QUAD && prev == 2'h0 && level == 2'h2 && ratio.num != 16'h0000
      |-> delta < 0)
      else $error("phase b leading did not count down");

   a_quad_illegal: assert property (  // [R12]
      mode == PCD_MODE_QUAD && chg == 2'h3 |-> delta == 0 ##1 status.quadError)
      else $error("simultaneous quadrature change was not ignored and flagged");

   a_ratio_drain: assert property (  // [R05]
      sum >= denS |=> status.position == $past(st.position) + 32'sh0000_0001)
      else $error("accumulated ratio did not advance position");

   a_pwm50_zero: assert property (  // [R09]
      mode == PCD_MODE_PWM50 && st.windowCnt == PWM_WIN_LAST
      && highNext == 11'(PWM_WINDOW_CYC / 2) |=> status.command == 0 && status.commandValid)
      else $error("half duty did not give zero command");

   a_pwm50_full: assert property (  // [R10]
      mode == PCD_MODE_PWM50 && st.windowCnt == PWM_WIN_LAST && highNext == 11'h000
      |=> status.command == -$signed(PWM_FULL))
      else $error("zero duty did not give negative full scale");

   a_pwmdir_sign: assert property (  // [R07] [R08]
      mode == PCD_MODE_PWMDIR && st.windowCnt == PWM_WIN_LAST && !level[1] && highNext != 0
      |=> status.command < 0)
      else $error("direction low did not give negative command");

   a_pwmdir_pos: assert property (  // [R08]
      mode == PCD_MODE_PWMDIR && st.windowCnt == PWM_WIN_LAST && level[1] && highNext != 0
      |=> status.command > 0)
      else $error("direction high did not give positive command");

   c_step_pulse:  cover property (mode == PCD_MODE_STEP && rise[0] ##[1:20] rise[0]);
   c_quad_error:  cover property (status.quadError);
   c_pwm_command: cover property (mode == PCD_MODE_PWM50 && status.commandValid);
   c_pwmdir_cmd:  cover property (mode == PCD_MODE_PWMDIR && status.commandValid);
   c_quad_count:  cover property (mode == PCD_MODE_QUAD && chg != 2'h0 && chg != 2'h3);
endmodule
`default_nettype wire

// [hdl/pcd_pkg.sv]
// pulse command decoder: shared constants, modes and carrier types
package pcd_pkg;
   // =====================================================================
   // timing
   localparam int          CLK_PERIOD_NS  = 100;
   localparam int          PWM_WINDOW_NS  = 102400;
   localparam int          PWM_WINDOW_CYC = PWM_WINDOW_NS / CLK_PERIOD_NS;
   localparam logic [10:0] PWM_WIN_LAST   = 11'(PWM_WINDOW_CYC - 1);
   localparam logic [11:0] PWM_FULL       = 12'(PWM_WINDOW_CYC);

   // =====================================================================
   // widths and reset values
   localparam int                 POS_W     = 32;
   localparam int                 ACC_W     = 25;
   localparam int                 CMD_W     = 12;
   localparam logic signed [31:0] POS_RESET = 32'sh0000_0000;
   localparam logic signed [24:0] ACC_RESET = 25'sh000_0000;
   localparam logic [10:0]        CNT_RESET = 11'h000;
   localparam logic [1:0]         SYNC_RESET = 2'h0;
   localparam logic signed [11:0] CMD_RESET = 12'sh000;

   // =====================================================================
   // command formats, one-hot
   typedef enum logic [4:0] {
      PCD_MODE_STEP   = 5'h01,  // step with direction
      PCD_MODE_UPDN   = 5'h02,  // up_down_pulse_format
      PCD_MODE_QUAD   = 5'h04,  // a/b quadrature, electronic gearing
      PCD_MODE_PWMDIR = 5'h08,  // pwm magnitude with direction
      PCD_MODE_PWM50  = 5'h10   // single signal pwm, half duty is zero
   } pcd_mode_t;

   typedef struct packed {
      logic [15:0] num;  // motor counts per ratio unit
      logic [15:0] den;  // input pulses per ratio unit
   } pcd_ratio_t;

   typedef struct packed {
      logic signed [POS_W-1:0] position;      // commanded motor position
      logic signed [CMD_W-1:0] command;       // velocity or torque command
      logic                    commandValid;  // command updated this cycle
      logic                    quadError;     // both quadrature inputs moved
   } pcd_out_t;

   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
      logic [1:0] s3;
   } pcd_sync_t;

   typedef struct packed {
      logic signed [POS_W-1:0] position;
      logic signed [ACC_W-1:0] acc;
      logic [10:0]             windowCnt;
      logic [10:0]             highCnt;
      logic signed [CMD_W-1:0] command;
      logic                    commandValid;
      logic                    quadError;
   } pcd_state_t;
endpackage

// [hdl/pcd_sync.sv]
// pulse command decoder: two-stage input synchroniser with a history stage
`timescale 1ns/1ns
`default_nettype none
module pcd_sync (
   input  wire logic       clk,    // system clock
   input  wire logic       reset,  // synchronous, active high
   input  wire logic [1:0] din,    // raw command inputs
   output logic      [1:0] level,  // synchronised level
   output logic      [1:0] prev    // level one cycle earlier
);
   import pcd_pkg::*;

   pcd_sync_t st;
   pcd_sync_t next_st;

   // =====================================================================
   // s1 is read only by s2; edges are taken from s2 against s3
   always_comb begin
      next_st    = st;
      next_st.s1 = din;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st <= {SYNC_RESET, SYNC_RESET, SYNC_RESET};
      end else begin
         st <= next_st;
      end
   end

   assign level = st.s2;
   assign prev  = st.s3;
endmodule
`default_nettype wire
